// ==== hw/bcgu_params.svh ====
// Constants for the base clock generation unit
// Function
// (RULE1) Twelve base clocks, index ten reserved
// (RULE2) Safe clock runs from ring oscillator only
// (RULE3) Control clock fixed to ring oscillator
// (RULE4) Ring oscillator cannot be powered down
// (RULE5) Outputs select divider, PLL, ring or crystal
// (RULE6) Dividers select PLL or primary oscillator
// (RULE7) PLL input comes from crystal oscillator
// (RULE8) PLL gives 0, 120, 240 degree phases
// (RULE9) Illegal source keeps select, other fields written
// (RULE10) Reset selects ring oscillator everywhere
// (RULE11) Software switches system clock after checking
// (RULE12) Per-source presence; inactive selections masked
// (RULE13) Detector events on activation and deactivation
// (RULE14) No edge within 32 ticks means inactive
// (RULE15) All absent after reset, valid after 32
// (RULE16) Dead selected clock may pass, event raised
// (RULE17) PLL switch holds output low until lock
// (RULE18) Non-PLL switches glitch-free, brief low gap
// (RULE19) Stuck-high clock forced low after 32 ticks
// (RULE20) Extra phases enabled, synchronised on lock
// (RULE21) Post divider 2/4/8/16 or direct
// (RULE22) Powerdown resets dividers, drops lock
`ifndef BCGU_PARAMS_SVH
`define BCGU_PARAMS_SVH

// Source codes
`define BCGU_SRC_RING 4'h0
`define BCGU_SRC_XTAL 4'h1
`define BCGU_SRC_PLL2 4'h4
`define BCGU_SRC_PLL0 4'h2
`define BCGU_SRC_LAST 4'hB

// Output numbers with restrictions
`define BCGU_OUT_SAFE 0
`define BCGU_OUT_PCR 2
`define BCGU_OUT_RSVD 10

// Detector and switch timeout in slow ticks
`define BCGU_DET_LIMIT 6'h20

// Register addresses
`define BCGU_OUT_BASE 8'h00
`define BCGU_DIV_BASE 8'h40
`define BCGU_PLL_CTRL 8'h60
`define BCGU_PRESENCE 8'h64
`define BCGU_PLL_STAT 8'h68

// Field positions
`define BCGU_SEL_MSB 3
`define BCGU_SEL_LSB 0
`define BCGU_BUSY_BIT 8
`define BCGU_L_MSB 15
`define BCGU_L_LSB 8
`define BCGU_D_MSB 23
`define BCGU_D_LSB 16
`define BCGU_PD_BIT 0
`define BCGU_DIRECT_BIT 1
`define BCGU_PSEL_MSB 3
`define BCGU_PSEL_LSB 2
`define BCGU_EXTRA_BIT 4

// Reset values
`define BCGU_PLL_CTRL_RST 5'h01
`define BCGU_DIV_L_RST 8'h01
`define BCGU_DIV_D_RST 8'h02

`endif

// ==== hw/bcgu_pkg.sv ====
// Types for the base clock generation unit
package bcgu_pkg;
  typedef enum logic [1:0] {SW_RUN, SW_WAIT_LOW, SW_HOLD, SW_WAIT_LOCK} bcgu_sw_state_e;
  typedef logic [3:0] bcgu_src_t;
endpackage

// ==== hw/bcgu_top.sv ====
// Base clock generation unit: sources, dividers, PLL post stage, detectors, output switches
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "bcgu_params.svh"
module bcgu_top
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Source pins
  input wire logic ring_oscillator,
  input wire logic xtal_clk,
  input wire logic [2:0] controlled_oscillator,
  input wire logic pll_analog_lock,
  // PLL status and control
  output logic pll_powerdown,
  output logic pll_lock,
  output logic [2:0] pll_main_output,
  // Base clocks
  output logic [11:0] base_clk,
  // Detector state and events
  output logic [11:0] clock_presence_status,
  output logic [11:0] src_up_pulse,
  output logic [11:0] src_down_pulse
);

  localparam logic [11:0] FIXED_MASK = (12'h001 << `BCGU_OUT_SAFE) | (12'h001 << `BCGU_OUT_PCR);
  localparam logic [11:0] RSVD_MASK = 12'h001 << `BCGU_OUT_RSVD;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] pin_in;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic [5:0] lvl_q;
  assign pin_in = {pll_analog_lock, controlled_oscillator, xtal_clk, ring_oscillator};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Take new level only where stages two and three agree
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  // Ring oscillator has no powerdown control at all
  logic ring_prev_q; // RULE4
  logic slow_tick;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ring_prev_q <= 1'b0;
    else
      ring_prev_q <= lvl_q[0];
  end
  assign slow_tick = lvl_q[0] & ~ring_prev_q;

  // ----------------------------------------
  // Registers written by software
  // ----------------------------------------
  logic [4:0] pll_ctrl_q;
  logic pd;
  logic direct;
  logic [1:0] psel;
  logic extra;
  assign pd = pll_ctrl_q[`BCGU_PD_BIT];
  assign direct = pll_ctrl_q[`BCGU_DIRECT_BIT];
  assign psel = pll_ctrl_q[`BCGU_PSEL_MSB:`BCGU_PSEL_LSB];
  assign extra = pll_ctrl_q[`BCGU_EXTRA_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pll_ctrl_q <= `BCGU_PLL_CTRL_RST;
    else if (reg_wr && reg_addr == `BCGU_PLL_CTRL)
      pll_ctrl_q <= reg_wdata[4:0];
  end

  // ----------------------------------------
  // PLL post stage, fed from crystal
  // ----------------------------------------
  // The analog loop is referenced to xtal_clk outside this block
  logic [2:0] cco_lvl; // RULE7
  logic [2:0] cco_prev_q;
  logic [2:0] cco_rise;
  logic [3:0] pdiv_q [3];
  logic lock_prev_q;
  logic pll_lock_q;
  logic [2:0] pll_out_q;
  assign cco_lvl = lvl_q[4:2];
  assign cco_rise = cco_lvl & ~cco_prev_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cco_prev_q <= '0;
      pll_lock_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end
    else
    begin
      cco_prev_q <= cco_lvl;
      pll_lock_q <= ~pd & lvl_q[5]; // RULE22
      lock_prev_q <= pll_lock_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || pd)
    begin
      pdiv_q[0] <= '0; // RULE22
      pdiv_q[1] <= '0;
      pdiv_q[2] <= '0;
      pll_out_q <= '0;
    end
    else
    begin
      if (cco_rise[0])
        pdiv_q[0] <= pdiv_q[0] + 4'h1;
      for (int k = 1; k < 3; k++)
      begin
        if (!extra)
          pdiv_q[k] <= '0; // RULE20
        else if (pll_lock_q && !lock_prev_q)
          pdiv_q[k] <= pdiv_q[0]; // RULE20
        else if (cco_rise[k])
          pdiv_q[k] <= pdiv_q[k] + 4'h1;
      end
      // Three phases, extra two only when enabled
      for (int k = 0; k < 3; k++)
      begin
        if (k != 0 && !extra)
          pll_out_q[k] <= 1'b0; // RULE8
        else if (direct)
          pll_out_q[k] <= cco_lvl[k]; // RULE21
        else
          pll_out_q[k] <= pdiv_q[k][psel]; // RULE21
      end
    end
  end

  // ----------------------------------------
  // Source vector
  // ----------------------------------------
  logic [6:0] fdiv_q;
  logic [11:0] src_lvl;
  logic [11:0] src_prev_q;
  logic [11:0] src_rise;
  assign src_lvl = {fdiv_q, pll_out_q, lvl_q[1], lvl_q[0]}; // RULE5
  assign src_rise = src_lvl & ~src_prev_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      src_prev_q <= '0;
    else
      src_prev_q <= src_lvl;
  end

  // ----------------------------------------
  // Activity detectors
  // ----------------------------------------
  logic [5:0] det_cnt_q [12];
  logic [11:0] pres_q;
  logic [11:0] up_q;
  logic [11:0] down_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pres_q <= '0; // RULE15
      up_q <= '0;
      down_q <= '0;
      for (int i = 0; i < 12; i++)
        det_cnt_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 12; i++)
      begin
        up_q[i] <= 1'b0;
        down_q[i] <= 1'b0;
        if (src_rise[i])
        begin
          det_cnt_q[i] <= '0; // RULE14
          pres_q[i] <= 1'b1;
          up_q[i] <= ~pres_q[i]; // RULE13
        end
        else if (slow_tick && det_cnt_q[i] != `BCGU_DET_LIMIT)
        begin
          det_cnt_q[i] <= det_cnt_q[i] + 6'h01;
          if (det_cnt_q[i] + 6'h01 == `BCGU_DET_LIMIT)
          begin
            pres_q[i] <= 1'b0; // RULE14
            down_q[i] <= pres_q[i]; // RULE16
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Fractional dividers
  // ----------------------------------------
  bcgu_pkg::bcgu_src_t div_sel_q [7];
  logic [7:0] div_l_q [7];
  logic [7:0] div_d_q [7];
  logic [8:0] div_acc_q [7];
  logic div_hit;
  logic [2:0] div_idx;
  bcgu_pkg::bcgu_src_t wr_sel;
  assign wr_sel = reg_wdata[`BCGU_SEL_MSB:`BCGU_SEL_LSB];
  assign div_hit = reg_addr[7:5] == `BCGU_DIV_BASE >> 5 && reg_addr[1:0] == 2'h0 && reg_addr[4:2] != 3'h7;
  assign div_idx = reg_addr[4:2];

  genvar gd;
  generate
    for (gd = 0; gd < 7; gd++)
    begin : g_div
      logic [8:0] acc_n;
      assign acc_n = div_acc_q[gd] + {1'b0, div_l_q[gd]};
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          div_sel_q[gd] <= `BCGU_SRC_RING; // RULE10
          div_l_q[gd] <= `BCGU_DIV_L_RST;
          div_d_q[gd] <= `BCGU_DIV_D_RST;
        end
        else if (reg_wr && div_hit && div_idx == gd)
        begin
          div_l_q[gd] <= reg_wdata[`BCGU_L_MSB:`BCGU_L_LSB]; // RULE9
          div_d_q[gd] <= reg_wdata[`BCGU_D_MSB:`BCGU_D_LSB];
          // Never another divider; only present sources
          if (wr_sel <= `BCGU_SRC_PLL2 && pres_q[wr_sel]) // RULE6
            div_sel_q[gd] <= wr_sel; // RULE12
        end
      end
      // Output is a toggle flop, so a source change cannot glitch it
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          div_acc_q[gd] <= '0;
          fdiv_q[gd] <= 1'b0;
        end
        else if (src_rise[div_sel_q[gd]])
        begin
          if (acc_n >= {1'b0, div_d_q[gd]})
          begin
            div_acc_q[gd] <= acc_n - {1'b0, div_d_q[gd]};
            fdiv_q[gd] <= ~fdiv_q[gd]; // RULE18
          end
          else
            div_acc_q[gd] <= acc_n;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Output generators with switch sequencing
  // ----------------------------------------
  bcgu_pkg::bcgu_src_t out_sel_q [12];
  bcgu_pkg::bcgu_src_t pend_sel_q [12];
  logic [11:0] pend_v_q;
  bcgu_pkg::bcgu_sw_state_e sw_q [12];
  logic [5:0] sw_cnt_q [12];
  logic [11:0] base_clk_q;
  logic out_hit;
  logic [3:0] out_idx;
  assign out_hit = reg_addr[7:6] == `BCGU_OUT_BASE >> 6 && reg_addr[1:0] == 2'h0 && reg_addr[5:2] <= 4'hB;
  assign out_idx = reg_addr[5:2];

  genvar go;
  generate
    for (go = 0; go < 12; go++)
    begin : g_out
      logic wr_ok;
      logic pll_new;
      logic stuck;
      // Safe and control outputs take only the ring code; reserved takes none
      assign wr_ok = reg_wr && out_hit && out_idx == go && !RSVD_MASK[go] && wr_sel <= `BCGU_SRC_LAST
        && (!FIXED_MASK[go] || wr_sel == `BCGU_SRC_RING) && pres_q[wr_sel]; // RULE12
      assign pll_new = pend_sel_q[go] >= `BCGU_SRC_PLL0 && pend_sel_q[go] <= `BCGU_SRC_PLL2;
      assign stuck = sw_cnt_q[go] == `BCGU_DET_LIMIT;

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          pend_v_q[go] <= 1'b0;
          pend_sel_q[go] <= `BCGU_SRC_RING;
        end
        else if (wr_ok)
        begin
          pend_v_q[go] <= 1'b1; // RULE9
          pend_sel_q[go] <= wr_sel; // RULE2 RULE3
        end
        else if (sw_q[go] == bcgu_pkg::SW_WAIT_LOW && (base_clk_q[go] == 1'b0 || stuck))
          pend_v_q[go] <= 1'b0;
      end

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          sw_q[go] <= bcgu_pkg::SW_RUN;
          out_sel_q[go] <= `BCGU_SRC_RING; // RULE10
          sw_cnt_q[go] <= '0;
        end
        else
        begin
          unique case (sw_q[go])
            bcgu_pkg::SW_RUN:
            begin
              sw_cnt_q[go] <= '0;
              if (pend_v_q[go])
                sw_q[go] <= bcgu_pkg::SW_WAIT_LOW;
            end
            bcgu_pkg::SW_WAIT_LOW:
            begin
              if (slow_tick && !stuck)
                sw_cnt_q[go] <= sw_cnt_q[go] + 6'h01; // RULE19
              if (base_clk_q[go] == 1'b0 || stuck)
              begin
                out_sel_q[go] <= pend_sel_q[go];
                sw_q[go] <= pll_new ? bcgu_pkg::SW_WAIT_LOCK : bcgu_pkg::SW_HOLD; // RULE17
              end
            end
            bcgu_pkg::SW_HOLD:
              sw_q[go] <= bcgu_pkg::SW_RUN; // RULE18
            bcgu_pkg::SW_WAIT_LOCK:
              if (pll_lock_q)
                sw_q[go] <= bcgu_pkg::SW_RUN; // RULE17
          endcase
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n || RSVD_MASK[go])
          base_clk_q[go] <= 1'b0; // RULE1
        else if (sw_q[go] == bcgu_pkg::SW_RUN)
          base_clk_q[go] <= src_lvl[out_sel_q[go]]; // RULE16
        else if (sw_q[go] == bcgu_pkg::SW_WAIT_LOW)
          base_clk_q[go] <= src_lvl[out_sel_q[go]] & ~stuck; // RULE19
        else
          base_clk_q[go] <= 1'b0; // RULE17 RULE18
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [31:0] rdata_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (reg_rd)
    begin
      rdata_q <= '0;
      if (out_hit)
      begin
        rdata_q[`BCGU_SEL_MSB:`BCGU_SEL_LSB] <= out_sel_q[out_idx];
        rdata_q[`BCGU_BUSY_BIT] <= sw_q[out_idx] != bcgu_pkg::SW_RUN;
      end
      else if (div_hit)
        rdata_q <= {8'h00, div_d_q[div_idx], div_l_q[div_idx], 4'h0, div_sel_q[div_idx]};
      else if (reg_addr == `BCGU_PLL_CTRL)
        rdata_q <= {27'h0, pll_ctrl_q};
      else if (reg_addr == `BCGU_PRESENCE)
        rdata_q <= {20'h0, pres_q}; // RULE12
      else if (reg_addr == `BCGU_PLL_STAT)
        rdata_q <= {31'h0, pll_lock_q};
    end
  end

  assign reg_rdata = rdata_q;
  assign pll_powerdown = pd;
  assign pll_lock = pll_lock_q;
  assign pll_main_output = pll_out_q;
  assign base_clk = base_clk_q;
  assign clock_presence_status = pres_q;
  assign src_up_pulse = up_q;
  assign src_down_pulse = down_q;

endmodule
`default_nettype wire

// ==== verification/base_clock_generation_unit_bench.sv ====
// Self-checking bench for the base clock generation unit
`timescale 1ns/10ps
`default_nettype none
module base_clock_generation_unit_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic xtal_en = 1'b1;
  logic xtal_stop = 1'b1;
  logic lock_en = 1'b0;
  logic [31:0] reg_rdata;
  logic ring_oscillator, xtal_clk, pll_analog_lock, pll_powerdown, pll_lock;
  logic [2:0] controlled_oscillator, pll_main_output;
  logic [11:0] base_clk, clock_presence_status, src_up_pulse, src_down_pulse;
  wire logic [14:0] mon = {pll_main_output, base_clk};
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  int p;
  logic hi;
  logic [31:0] d;
  logic [7:0] lv, dv, ja;
  logic [7:0] bad_a [5] = '{8'h00, 8'h08, 8'h28, 8'h04, 8'h0C};
  logic [31:0] bad_v [5] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'hC};
  always #20 clk_sys = ~clk_sys;
  bcgu_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ring_oscillator(ring_oscillator), .xtal_clk(xtal_clk),
    .controlled_oscillator(controlled_oscillator), .pll_analog_lock(pll_analog_lock),
    .pll_powerdown(pll_powerdown), .pll_lock(pll_lock), .pll_main_output(pll_main_output), .base_clk(base_clk),
    .clock_presence_status(clock_presence_status), .src_up_pulse(src_up_pulse), .src_down_pulse(src_down_pulse));
  bcgu_src_model src (.clk_sys(clk_sys), .xtal_en(xtal_en), .xtal_stop(xtal_stop), .lock_en(lock_en),
    .pll_powerdown(pll_powerdown), .ring_oscillator(ring_oscillator), .xtal_clk(xtal_clk),
    .controlled_oscillator(controlled_oscillator), .pll_analog_lock(pll_analog_lock));
  // --------
  // Tasks
  // --------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // Read until match or give up
  task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] e);
    int k;
    rd(a, d);
    for (k = 0; k < 40 && d !== e; k++)
      rd(a, d);
    chk(nm, d, e);
  endtask
  // Cycles between two rising edges of a monitored clock
  task automatic period(input int b, output int q);
    int k;
    int t0;
    logic pv;
    q = 0;
    t0 = -1;
    pv = 1'b1;
    for (k = 0; k < 1200 && q == 0; k++)
    begin
      @(posedge clk_sys);
      #1;
      if (mon[b] === 1'b1 && pv === 1'b0)
      begin
        if (t0 >= 0)
          q = k - t0;
        t0 = k;
      end
      pv = mon[b];
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // --------
  // Sequence
  // --------
  initial
  begin
    void'($urandom(76));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i++)
      poll("out_rst", 8'(4 * i), 32'h0);
    for (i = 0; i < 7; i++)
      poll("div_rst", 8'(8'h40 + 4 * i), 32'h0002_0100);
    poll("pll_rst", 8'h60, 32'h1);
    wr(8'h70, 32'hFFFF_FFFF);
    poll("unmapped", 8'h70, 32'h0);
    $display("done reset values");
    repeat (700) @(posedge clk_sys);
    poll("presence", 8'h64, 32'hFE3);
    for (i = 0; i < 5; i++)
    begin
      wr(bad_a[i], bad_v[i]);
      poll("bad_sel", bad_a[i], 32'h0);
    end
    ja = 8'(8'h40 + 4 * $urandom_range(6));
    lv = 8'($urandom_range(255, 1));
    dv = 8'($urandom_range(255, 1));
    wr(ja, {8'h00, dv, lv, 8'h05});
    poll("div_keep", ja, {8'h00, dv, lv, 8'h00});
    wr(ja, 32'h0002_0101);
    poll("div_xtal", ja, 32'h0002_0101);
    wr(8'h04, 32'h1);
    poll("sys_xtal", 8'h04, 32'h1);
    period(1, p);
    chk("sys_period", 32'(p), 32'd8);
    $display("done selection");
    wr(8'h60, 32'h0);
    repeat (100) @(posedge clk_sys);
    wr(8'h0C, 32'h2);
    poll("pll_wait", 8'h0C, 32'h102);
    hi = 1'b0;
    repeat (200)
    begin
      @(posedge clk_sys);
      hi = hi | base_clk[3];
    end
    chk("pll_hold", {31'h0, hi}, 32'h0);
    lock_en <= 1'b1;
    poll("lock", 8'h68, 32'h1);
    poll("pll_run", 8'h0C, 32'h2);
    period(3, p);
    chk("pll_out", 32'(p), 32'd24);
    for (i = 0; i < 4; i++)
    begin
      wr(8'h60, 32'(i << 2));
      period(12, p);
      period(12, p);
      chk("post_div", 32'(p), 32'(24 << i));
      chk("extra_off", {29'h0, pll_main_output[2:1], 1'b0}, 32'h0);
    end
    wr(8'h60, 32'h2);
    period(12, p);
    period(12, p);
    chk("direct", 32'(p), 32'd12);
    wr(8'h60, 32'h10);
    period(13, p);
    period(13, p);
    chk("phase2", 32'(p), 32'd24);
    period(14, p);
    chk("phase3", 32'(p), 32'd24);
    wr(8'h60, 32'h1);
    poll("lock_pd", 8'h68, 32'h0);
    repeat (10) @(posedge clk_sys);
    chk("pd_out", {29'h0, pll_main_output}, 32'h0);
    $display("done pll");
    xtal_en <= 1'b0;
    repeat (700) @(posedge clk_sys);
    rd(8'h64, d);
    chk("xtal_gone", {31'h0, d[1]}, 32'h0);
    chk("dead_pass", {31'h0, base_clk[1]}, 32'h1);
    wr(8'h04, 32'h0);
    repeat (300) @(posedge clk_sys);
    rd(8'h04, d);
    chk("stuck_wait", d, 32'h101);
    repeat (300) @(posedge clk_sys);
    poll("forced_low", 8'h04, 32'h0);
    $display("done detection");
    tally_and_finish();
  end
endmodule
bind bcgu_top bcgu_top_sva sva_i (.clk_sys(clk_sys), .rst_n(rst_n), .ring_oscillator(ring_oscillator),
  .xtal_clk(xtal_clk), .pll_powerdown(pll_powerdown), .pll_lock(pll_lock), .pll_main_output(pll_main_output),
  .base_clk(base_clk), .clock_presence_status(clock_presence_status), .src_up_pulse(src_up_pulse),
  .src_down_pulse(src_down_pulse));
`default_nettype wire

// ==== verification/bcgu_src_model.sv ====
// Source clock model: ring, crystal, PLL oscillator phases and lock
`timescale 1ns/10ps
`default_nettype none
module bcgu_src_model
(
  // Bench controls
  input wire logic clk_sys,
  input wire logic xtal_en,
  input wire logic xtal_stop,
  input wire logic lock_en,
  input wire logic pll_powerdown,
  // Source pins
  output logic ring_oscillator,
  output logic xtal_clk,
  output logic [2:0] controlled_oscillator,
  output logic pll_analog_lock
);
  logic [3:0] ring_q = 4'h0;
  logic [2:0] xt_q = 3'h0;
  logic [3:0] cco_q = 4'h0;
  logic [5:0] lock_q = 6'h00;
  // --------
  // Counters
  // --------
  always_ff @(posedge clk_sys)
    ring_q <= ring_q + 4'h1;
  always_ff @(posedge clk_sys)
    xt_q <= xt_q + 3'h1;
  always_ff @(posedge clk_sys)
    cco_q <= (pll_powerdown || !xtal_en || cco_q == 4'hB) ? 4'h0 : cco_q + 4'h1;
  always_ff @(posedge clk_sys)
    lock_q <= (!lock_en || pll_powerdown) ? 6'h00 : (lock_q == 6'h28 ? lock_q : lock_q + 6'h01);
  // --------
  // Pins
  // --------
  assign ring_oscillator = ring_q[3];
  assign xtal_clk = xtal_en ? xt_q[2] : xtal_stop;
  assign controlled_oscillator[0] = !pll_powerdown && cco_q < 4'h6;
  assign controlled_oscillator[1] = !pll_powerdown && cco_q >= 4'h4 && cco_q < 4'hA;
  assign controlled_oscillator[2] = !pll_powerdown && (cco_q >= 4'h8 || cco_q < 4'h2);
  assign pll_analog_lock = lock_q == 6'h28;
endmodule
`default_nettype wire

// ==== verification/bcgu_top_sva.sv ====
// Port checker for the base clock generation unit
`timescale 1ns/10ps
`default_nettype none
module bcgu_top_sva
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Source pins
  input wire logic ring_oscillator,
  input wire logic xtal_clk,
  // Outputs watched
  input wire logic pll_powerdown,
  input wire logic pll_lock,
  input wire logic [2:0] pll_main_output,
  input wire logic [11:0] base_clk,
  input wire logic [11:0] clock_presence_status,
  input wire logic [11:0] src_up_pulse,
  input wire logic [11:0] src_down_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic ring_d_q;
  logic xt_d_q;
  logic [6:0] gap_q;
  // --------
  // Ring ticks since last crystal edge
  // --------
  always_ff @(posedge clk_sys)
  begin
    ring_d_q <= ring_oscillator;
    xt_d_q <= xtal_clk;
    if (!rst_n || (xtal_clk && !xt_d_q))
      gap_q <= 7'h00;
    else if (ring_oscillator && !ring_d_q && gap_q != 7'h7F)
      gap_q <= gap_q + 7'h01;
  end
  // --------
  // Properties
  // --------
  AST_RSVD: assert property (base_clk[10] == 1'b0) else $error("reserved clock moved");
  AST_SAFE_PCR: assert property (base_clk[0] == base_clk[2]) else $error("safe and control clocks differ");
  AST_LOCK_PD: assert property (pll_powerdown && $past(pll_powerdown) |-> !pll_lock)
    else $error("lock while powered down");
  AST_PD_OUT: assert property (pll_powerdown [*3] |-> pll_main_output == 3'h0)
    else $error("PLL output while powered down");
  AST_EVT_LEVEL: assert property (((src_up_pulse & ~clock_presence_status)
    | (src_down_pulse & clock_presence_status)) == 12'h000) else $error("event against presence");
  AST_UP: assert property ($rose(clock_presence_status[1]) |-> ##[0:1] src_up_pulse[1])
    else $error("no up event");
  AST_DOWN: assert property ($fell(clock_presence_status[1]) |-> ##[0:1] src_down_pulse[1])
    else $error("no down event");
  AST_BOUND: assert property (clock_presence_status[1] |-> gap_q <= 7'd34)
    else $error("present without edges");
  AST_FALL: assert property ($fell(clock_presence_status[1]) |-> gap_q >= 7'd31)
    else $error("absent too early");
  AST_START: assert property ($rose(rst_n) |-> clock_presence_status == 12'h000 && base_clk[1] == 1'b0)
    else $error("not clear after reset");
endmodule
`default_nettype wire
